// ===== sbio_consts.vh
`ifndef SBIO_CONSTS_VH
`define SBIO_CONSTS_VH
`define SBIO_ADDR_BASE    6'h10
`define SBIO_REG_INPUT    8'h00
`define SBIO_REG_OUTPUT   8'h01
`define SBIO_REG_INVERT   8'h02
`define SBIO_REG_DIR      8'h03
`define SBIO_RST_OUTPUT   8'hFF
`define SBIO_RST_INVERT   8'h00
`define SBIO_RST_DIR      8'hFF
`define SBIO_RW_BIT       0
`define SBIO_INT_DELAY    1
`endif

// ===== sbio_regs.v
`timescale 1ns/1ps
`include "sbio_consts.vh"
module sbio_regs #(
	parameter WIDTH = 8
) (
	input  wire             clk_sys,
	input  wire             rst,
	input  wire             wr_en,
	input  wire [1:0]       wr_sel,
	input  wire [WIDTH-1:0] wr_data,
	input  wire [1:0]       rd_sel,
	input  wire [WIDTH-1:0] in_value,
	output reg  [WIDTH-1:0] rd_data,
	output reg  [WIDTH-1:0] drive_level_latch,
	output reg  [WIDTH-1:0] input_invert_mask,
	output reg  [WIDTH-1:0] direction_select
);
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			drive_level_latch <= `SBIO_RST_OUTPUT;
			input_invert_mask <= `SBIO_RST_INVERT;
			direction_select  <= `SBIO_RST_DIR;
		end else if (wr_en) begin
			case (wr_sel)
			2'h1: drive_level_latch <= wr_data;
			2'h2: input_invert_mask <= wr_data;
			2'h3: direction_select <= wr_data;
			default: ; // Input register ignores writes
			endcase
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else begin
			case (rd_sel)
			2'h0: rd_data <= in_value;
			2'h1: rd_data <= drive_level_latch; // Latch, not pins
			2'h2: rd_data <= input_invert_mask;
			default: rd_data <= direction_select;
			endcase
		end
	end
endmodule // sbio_regs

// ===== sbio_expander.v
`timescale 1ns/1ps
`include "sbio_consts.vh"
// Notes on behaviour
// - Select pin picks address; LSB one reads
// - First write byte loads write-only pointer
// - Pointer 0..3 selects the four registers
// - Input register shows pins; writes ignored
// - Input register follows pins after reset
// - Output latch resets ones, read returns latch
// - Invert bit flips sampled input level
// - Direction one is input; resets ones
// - Outputs driven both ways; inputs released
// - Power-on reset initialises everything
// - Reset pin low initialises everything
// - Input pin edge asserts interrupt low
// - Interrupt clears on return or input register read ack
// - Every later change re-raises interrupt
// - Output pins never interrupt
// - Write: address, command, data bytes
// - Read after repeated start returns register
// - Fresh data loaded at each ack clock
module sbio_expander #(
	parameter WIDTH = 8
) (
	input  wire             clk_sys,
	input  wire             rst,
	input  wire             reset_n,
	input  wire             addr_sel,
	input  wire             scl_in,
	input  wire             sda_in,
	output wire             sda_out,
	output wire             sda_oe,
	input  wire [WIDTH-1:0] port_in,
	output wire [WIDTH-1:0] port_out,
	output wire [WIDTH-1:0] port_oe,
	output wire             int_n_out,
	output wire             int_n_oe
);
	localparam ST_IDLE = 6'h01;
	localparam ST_ADDR = 6'h02;
	localparam ST_AACK = 6'h04;
	localparam ST_RXB  = 6'h08;
	localparam ST_TXB  = 6'h10;
	localparam ST_DACK = 6'h20;

	reg  [5:0]       state;
	reg  [3:0]       bitcnt;
	reg  [7:0]       shreg;
	reg  [7:0]       pointer;
	reg              is_read;
	reg              have_cmd;
	reg              sda_drv;
	reg              scl_q;
	reg              sda_q;
	reg              addr_q;
	reg              int_q;
	reg  [WIDTH-1:0] last_in;
	reg              primed;
	reg              snap_load;
	reg              wr_en;
	reg  [1:0]       rd_sel_q;
	wire [WIDTH-1:0] in_value;
	wire [WIDTH-1:0] rd_data;
	wire [WIDTH-1:0] drive_level_latch;
	wire [WIDTH-1:0] input_invert_mask;
	wire [WIDTH-1:0] direction_select;
	wire             core_rst;
	wire             scl_rise;
	wire             scl_fall;
	wire             start_c;
	wire             stop_c;
	wire [WIDTH-1:0] changed;

	// Seven address bits against base plus strap
	function addr_hit;
		input [7:0] b;
		input       a;
		begin
			addr_hit = (b[7:1] == {`SBIO_ADDR_BASE, a});
		end
	endfunction

	// Pointers above the four registers are acked but never write
	function wr_ok;
		input [7:0] p;
		begin
			wr_ok = (p[7:2] == 6'h00);
		end
	endfunction

	// Power-on reset is rst; pin reset joins it
	assign core_rst = rst | ~reset_n;

	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;

	// Pin levels on all pins, inverted where asked
	assign in_value = port_in ^ input_invert_mask;

	// Push-pull drive only when direction bit is zero
	assign port_oe  = ~direction_select;
	assign port_out = drive_level_latch;

	assign sda_out = 1'b0;
	assign sda_oe  = sda_drv;

	// Open drain: pull low while pending
	assign int_n_out = 1'b0;
	assign int_n_oe  = int_q;

	// Raw pins against snapshot, so an invert write alone raises nothing
	// Only input pins differing from last snapshot count
	assign changed = (port_in ^ last_in) & direction_select;

	sbio_regs #(
		.WIDTH(WIDTH)
	) u_regs (
		.clk_sys          (clk_sys),
		.rst              (core_rst),
		.wr_en            (wr_en),
		.wr_sel           (pointer[1:0]),
		.wr_data          (shreg),
		.rd_sel           (rd_sel_q),
		.in_value         (in_value),
		.rd_data          (rd_data),
		.drive_level_latch(drive_level_latch),
		.input_invert_mask(input_invert_mask),
		.direction_select (direction_select)
	);

	always @(posedge clk_sys or posedge core_rst) begin
		if (core_rst) begin
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			addr_q <= 1'b0;
		end else begin
			scl_q  <= scl_in;
			sda_q  <= sda_in;
			addr_q <= addr_sel;
		end
	end

	// Interrupt: level compare against last read snapshot
	always @(posedge clk_sys or posedge core_rst) begin
		if (core_rst) begin
			int_q <= 1'b0;
		end else begin
			int_q <= primed & (|changed);
		end
	end

	// Snapshot taken once after reset, then only by a read of a pointer whose bits 1:0 are zero;
	// it never follows the pins on its own, so idle edges still interrupt
	always @(posedge clk_sys or posedge core_rst) begin
		if (core_rst) begin
			primed  <= 1'b0;
			last_in <= {WIDTH{1'b0}};
		end else if (!primed || snap_load) begin
			primed  <= 1'b1;
			last_in <= port_in;
		end
	end

	always @(posedge clk_sys or posedge core_rst) begin
		if (core_rst) begin
			state    <= ST_IDLE;
			bitcnt   <= 4'h0;
			shreg    <= 8'h00;
			pointer  <= 8'h00;
			is_read  <= 1'b0;
			have_cmd <= 1'b0;
			sda_drv  <= 1'b0;
			wr_en    <= 1'b0;
			rd_sel_q <= 2'h0;
			snap_load <= 1'b0;
		end else begin
			wr_en     <= 1'b0;
			snap_load <= 1'b0;
			if (stop_c) begin
				state   <= ST_IDLE;
				sda_drv <= 1'b0;
			end else if (start_c) begin
				state    <= ST_ADDR;
				bitcnt   <= 4'h0;
				sda_drv  <= 1'b0;
				have_cmd <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: ;
				ST_ADDR: begin
					if (scl_rise) begin
						shreg  <= {shreg[6:0], sda_in};
						bitcnt <= bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						// Address match
						if (addr_hit(shreg, addr_q)) begin
							is_read <= shreg[`SBIO_RW_BIT];
							sda_drv <= 1'b1;
							state   <= ST_AACK;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (scl_rise && is_read)
						rd_sel_q <= pointer[1:0];
					if (scl_fall) begin
						bitcnt <= 4'h0;
						if (is_read) begin
							state   <= ST_TXB;
							shreg   <= rd_data;
							sda_drv <= ~rd_data[7];
						end else begin
							state   <= ST_RXB;
							sda_drv <= 1'b0;
						end
					end
				end
				ST_RXB: begin
					if (scl_rise) begin
						shreg  <= {shreg[6:0], sda_in};
						bitcnt <= bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						sda_drv <= 1'b1;
						state   <= ST_DACK;
						if (!have_cmd) begin
							pointer  <= shreg;
							have_cmd <= 1'b1;
						end else if (wr_ok(pointer)) begin
							wr_en <= 1'b1;
						end
					end
				end
				ST_TXB: begin
					if (scl_fall) begin
						bitcnt <= bitcnt + 4'h1;
						if (bitcnt == 4'h7) begin
							sda_drv <= 1'b0;
							state   <= ST_DACK;
						end else begin
							shreg   <= {shreg[6:0], 1'b0};
							sda_drv <= ~shreg[6];
						end
					end
				end
				ST_DACK: begin
					if (scl_rise && is_read) begin
						rd_sel_q <= pointer[1:0]; // Fresh sample
						if (pointer[1:0] == 2'h0)
							snap_load <= 1'b1; // Read clears interrupt
						if (sda_in)
							state <= ST_IDLE; // Master NACK ends read
					end else if (scl_fall) begin
						bitcnt <= 4'h0;
						if (is_read) begin
							state   <= ST_TXB;
							shreg   <= rd_data;
							sda_drv <= ~rd_data[7];
						end else begin
							sda_drv <= 1'b0;
							state   <= ST_RXB;
						end
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // sbio_expander

// ===== sbio_monitor.sv
`timescale 1ns/1ps
module sbio_monitor (
	input wire       clk_sys,
	input wire       rst,
	input wire       reset_n,
	input wire       addr_sel,
	input wire       scl_in,
	input wire       sda_in,
	input wire       sda_out,
	input wire       sda_oe,
	input wire [7:0] port_in,
	input wire [7:0] port_out,
	input wire [7:0] port_oe,
	input wire       int_n_out,
	input wire       int_n_oe
);
	default clocking mcb @(posedge clk_sys); endclocking
	default disable iff (rst || !reset_n);
	sequence s_start;
		scl_in && $fell(sda_in);
	endsequence
	sequence s_idle;
		(scl_in && sda_in) [*8];
	endsequence
	a_int_open_drain: assert property (int_n_out == 1'h0)
		else $error("int driven high");
	a_reset_pins_off: assert property (disable iff (1'h0)
		(rst || !reset_n) |=> port_oe == 8'h00) else $error("pins driven in reset");
	a_reset_latch_ones: assert property (disable iff (1'h0)
		(rst || !reset_n) |=> port_out == 8'hFF) else $error("latch not ones");
	a_regs_scl_low: assert property ($changed({port_out, port_oe}) |-> !scl_in)
		else $error("register moved, clock high");
	a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data moved, clock high");
	a_start_no_ack: assert property (s_start |=> !sda_oe [*8])
		else $error("early answer");
	a_idle_quiet: assert property (s_idle |-> !sda_oe)
		else $error("data held on idle bus");
	a_int_out_pins: assert property (port_oe == 8'hFF [*3] |-> !int_n_oe)
		else $error("int from outputs");
endmodule // sbio_monitor

// ===== sbio_master.sv
`timescale 1ns/1ps
module sbio_master (
	input  wire clk_sys,
	input  wire sda,
	output reg  scl,
	output reg  sda_low
);
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end
	task hp;
		repeat (5) @(negedge clk_sys);
	endtask
	// Doubles as repeated start
	task start;
		begin
			sda_low = 1'h0;
			hp;
			scl = 1'h1;
			hp;
			sda_low = 1'h1;
			hp;
			scl = 1'h0;
			hp;
		end
	endtask
	task stop;
		begin
			sda_low = 1'h1;
			hp;
			scl = 1'h1;
			hp;
			sda_low = 1'h0;
			hp;
		end
	endtask
	// Eight bits MSB first, then the acknowledge bit; a one releases the line
	task xb(input [8:0] d, output [8:0] q);
		integer i;
		begin
			for (i = 8; i >= 0; i = i - 1) begin
				sda_low = ~d[i];
				hp;
				scl = 1'h1;
				hp;
				q[i] = sda;
				scl = 1'h0;
				hp;
			end
			sda_low = 1'h0;
		end
	endtask
endmodule // sbio_master

// ===== serial_bus_io_expander_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks = checks + 1; if ((a) !== (e)) begin fails = fails + 1; \
	$display("BAD %0t got %h want %h", $time, a, e); end end
module serial_bus_io_expander_tb;
	reg        clk_sys = 1'h0;
	reg        rst = 1'h1;
	reg        reset_n = 1'h1;
	reg        addr_sel = 1'h0;
	reg  [7:0] ext = 8'h3C;
	reg  [8:0] q;
	integer    fails = 0;
	integer    checks = 0;
	wire       scl, sda_low, sda_oe;
	wire [7:0] port_out, port_oe;
	// Pull-up on the data line
	wire       sda = ~(sda_low | sda_oe);
	wire [7:0] pins = (port_oe & port_out) | (~port_oe & ext);
	always #10 clk_sys = ~clk_sys;
	sbio_master sbio_master_i (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
	sbio_expander sbio_expander_i (.clk_sys(clk_sys), .rst(rst), .reset_n(reset_n),
		.addr_sel(addr_sel), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.port_in(pins), .port_out(port_out), .port_oe(port_oe), .int_n_out(), .int_n_oe());
	task head(input [7:0] p);
		begin
			sbio_master_i.start;
			sbio_master_i.xb({6'h10, addr_sel, 2'h1}, q);
			`CHK(q[0], 1'h0)
			sbio_master_i.xb({p, 1'h1}, q);
		end
	endtask
	task wr(input [7:0] p, input [7:0] d);
		begin
			head(p);
			sbio_master_i.xb({d, 1'h1}, q);
			sbio_master_i.stop;
		end
	endtask
	task rd_open(input [7:0] p);
		begin
			head(p);
			sbio_master_i.start;
			sbio_master_i.xb({6'h10, addr_sel, 2'h3}, q);
		end
	endtask
	task rd(input [7:0] p, input [7:0] e);
		begin
			rd_open(p);
			sbio_master_i.xb(9'h1FF, q);
			sbio_master_i.stop;
			`CHK(q[8:1], e)
		end
	endtask
	task pin(input [7:0] v, input e);
		begin
			ext = v;
			repeat (4) @(negedge clk_sys);
			`CHK(sbio_expander_i.int_n_oe, e)
		end
	endtask
	task test_done;
		begin
			$display("checks %0d fails %0d", checks, fails);
			if (fails == 0 && checks > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	// Roughly five and a half times the expected run
	initial begin
		#1000000;
		fails = fails + 1;
		test_done;
	end
	initial begin
		repeat (3) @(negedge clk_sys);
		rst = 1'h0;
		repeat (2) @(negedge clk_sys);
		rd(8'h01, 8'hFF);
		rd(8'h02, 8'h00);
		rd(8'h03, 8'hFF);
		rd(8'h00, 8'h3C);
		$display("reset values done");
		wr(8'h03, 8'hF0);
		head(8'h01);
		sbio_master_i.xb(9'h14B, q);
		sbio_master_i.xb(9'h0B5, q);
		sbio_master_i.stop;
		`CHK(port_oe, 8'h0F)
		`CHK(port_out & port_oe, 8'h0A)
		rd(8'h01, 8'h5A);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h3A);
		wr(8'h02, 8'hF0);
		rd(8'h00, 8'hCA);
		$display("registers done");
		rd_open(8'h00);
		pin(8'hBC, 1'h1);
		sbio_master_i.xb(9'h1FF, q);
		`CHK(q[8:1], 8'hCA)
		`CHK(sbio_expander_i.int_n_oe, 1'h0)
		sbio_master_i.stop;
		rd_open(8'h00);
		pin(8'h3C, 1'h1);
		pin(8'hBC, 1'h0);
		sbio_master_i.xb(9'h1FF, q);
		sbio_master_i.stop;
		$display("interrupt done");
		pin(8'h3C, 1'h1);
		wr(8'h03, 8'h00);
		`CHK(sbio_expander_i.int_n_oe, 1'h0)
		reset_n = 1'h0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'h1;
		repeat (2) @(negedge clk_sys);
		rd(8'h03, 8'hFF);
		addr_sel = 1'h1;
		sbio_master_i.start;
		sbio_master_i.xb(9'h081, q);
		sbio_master_i.stop;
		`CHK(q[0], 1'h1)
		rd(8'h01, 8'hFF);
		$display("reset and address done");
		test_done;
	end
endmodule // serial_bus_io_expander_tb
bind sbio_expander sbio_monitor sbio_monitor_i (.clk_sys(clk_sys), .rst(rst),
	.reset_n(reset_n), .addr_sel(addr_sel), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .port_in(port_in), .port_out(port_out),
	.port_oe(port_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
